// *** common/dram_seq_pkg.sv ***
// Constants and carrier types for the special-mode command sequencer
package dram_seq_pkg;
    // Register map (word-aligned byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    // Control register field positions
    localparam int SEL_LSB = 4;
    localparam int SEL_MSB = 6;
    localparam int BURST_BIT = 2;
    localparam int KIND_LSB = 0;
    localparam int KIND_MSB = 1;
    // Reset values and memory kind codes
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic BURST_RESET = 1'h0;
    localparam logic [1:0] KIND_DDR = 2'h1;
    localparam logic [1:0] KIND_DDR2 = 2'h2;
    // Quadwords per burst
    localparam logic [3:0] BURST_SHORT = 4'h4;
    localparam logic [3:0] BURST_LONG = 4'h8;
    // Mode select encodings
    typedef enum logic [2:0] {
        MODE_POST_RESET = 3'h0,
        MODE_NOP = 3'h1,
        MODE_PRECHARGE = 3'h2,
        MODE_MRS = 3'h3,
        MODE_RSVD4 = 3'h4,
        MODE_RSVD5 = 3'h5,
        MODE_CBR = 3'h6,
        MODE_NORMAL = 3'h7
    } mode_t;
    // Memory command on the link
    typedef enum logic [2:0] {
        CMD_NOP,
        CMD_PRECHARGE_ALL,
        CMD_MODE_SET,
        CMD_REFRESH,
        CMD_READ,
        CMD_WRITE,
        CMD_SR_ENTER,
        CMD_SR_EXIT
    } cmd_t;
    // Command bundle driven to the memory
    typedef struct packed {
        logic valid;
        cmd_t cmd;
        logic [13:0] addr;
        logic [3:0] beats;
    } mem_cmd_t;
endpackage : dram_seq_pkg

// *** hdl/dram_special_mode_sequencer.sv ***
// Special-mode command sequencer between processor accesses and SDRAM
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dram_special_mode_sequencer #(
    parameter int RANKS = 4
) (
    // Clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    // Register port
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    // Processor access request
    input wire logic CPU_REQ_I,
    input wire logic CPU_WRITE_I,
    input wire logic [31:0] CPU_ADDRESS_BITS_I,
    output logic CPU_READY_O,
    // Power-management requests, asynchronous
    input wire logic SUSPEND_REQ_I,
    input wire logic LOWPOWER_REQ_I,
    output logic SELF_REFRESH_O,
    // Memory side
    output dram_seq_pkg::mem_cmd_t MEM_CMD_O,
    output logic [13:0] DRAM_ROW_COL_LINES_O,
    output logic [RANKS-1:0] CKE_O
);
    // Elaboration checks: values the logic cannot serve
    initial begin
        if (RANKS < 1 || RANKS > 8) begin
            $error("RANKS out of range");
        end
        // The mode decode assumes a three-bit field
        if (dram_seq_pkg::SEL_MSB - dram_seq_pkg::SEL_LSB != 2) begin
            $error("mode field must be three bits wide");
        end
        // The kind field is two bits
        if (dram_seq_pkg::KIND_MSB - dram_seq_pkg::KIND_LSB != 1) begin
            $error("kind field must be two bits wide");
        end
        // Bursts are counted down in four bits
        if (dram_seq_pkg::BURST_LONG <= dram_seq_pkg::BURST_SHORT) begin
            $error("long burst must exceed short burst");
        end
        if (dram_seq_pkg::BURST_SHORT == 4'h0) begin
            $error("short burst must not be empty");
        end
        // The decode chain needs two distinct addresses
        if (dram_seq_pkg::ADDR_CTRL == dram_seq_pkg::ADDR_STATUS) begin
            $error("control and status share an address");
        end
        if (dram_seq_pkg::BURST_BIT >= dram_seq_pkg::SEL_LSB) begin
            $error("burst bit overlaps the mode field");
        end
    end

    typedef enum logic [1:0] {
        PS_RUN,
        PS_FLUSH,
        PS_SELF_REFRESH,
        PS_EXIT
    } pstate_t;

    typedef struct packed {
        logic [2:0] special_command_sel;
        logic burst_size_sel;
        logic [1:0] sdram_kind;
        logic cke_on;
        pstate_t pstate;
        logic suspended;
        logic [1:0] sus_sync;
        logic [1:0] lp_sync;
        logic [31:0] rdata;
        dram_seq_pkg::mem_cmd_t cmd;
        logic [13:0] row_col;
        logic [3:0] beats_left;
    } state_t;

    // Local field positions and constants of the access path
    localparam int MRS_SRC_LSB = 3;
    localparam int MRS_SRC_MSB = 12;
    localparam int MRS_HI_SRC = 13;
    localparam int ROW_COL_MSB = 13;
    localparam logic [3:0] BEATS_NONE = 4'h0;
    localparam logic [3:0] BEAT_STEP = 4'h1;
    localparam logic [2:0] SEL_OFF = 3'h0;

    state_t s_q;
    state_t s_d;

    // Synchronised power requests
    logic sus_seen;
    logic lp_seen;
    logic pm_req;
    // Access path
    logic accept;
    logic cmd_ok;
    logic flush_go;
    logic burst_idle;
    logic [3:0] burst_beats;
    logic [13:0] mrs_lines;
    logic [13:0] plain_lines;
    // Register path
    logic ctrl_wr;
    logic ctrl_rd;
    logic status_rd;
    logic [2:0] wr_sel;
    logic [31:0] ctrl_view;
    logic [31:0] status_view;
    // Power sequencing
    logic sleeping;
    logic wake_ok;

    // Only the second flop of each chain is read
    assign sus_seen = s_q.sus_sync[1];
    assign lp_seen = s_q.lp_sync[1];
    assign pm_req = sus_seen | lp_seen;
    assign burst_idle = s_q.beats_left == BEATS_NONE;
    // Accesses are held off while a burst runs or the memory sleeps
    assign accept = CPU_REQ_I && s_q.pstate == PS_RUN && burst_idle && !pm_req;
    assign CPU_READY_O = accept;
    // Before the first nonzero mode write accesses are taken but issue nothing
    assign cmd_ok = accept && s_q.cke_on;
    // A power request wins over a waiting access
    assign flush_go = pm_req && s_q.cke_on;

    // beats per read follow the burst select
    assign burst_beats = s_q.burst_size_sel ? dram_seq_pkg::BURST_LONG
        : dram_seq_pkg::BURST_SHORT;
    // mode register operand from the access address, other lines low
    assign mrs_lines = {2'h0, CPU_ADDRESS_BITS_I[MRS_HI_SRC], 1'h0,
        CPU_ADDRESS_BITS_I[MRS_SRC_MSB:MRS_SRC_LSB]};
    assign plain_lines = CPU_ADDRESS_BITS_I[ROW_COL_MSB:0];

    assign ctrl_wr = REG_WR_I && REG_ADDR_I == dram_seq_pkg::ADDR_CTRL;
    assign ctrl_rd = REG_RD_I && REG_ADDR_I == dram_seq_pkg::ADDR_CTRL;
    assign status_rd = REG_RD_I && REG_ADDR_I == dram_seq_pkg::ADDR_STATUS;
    assign wr_sel = REG_WDATA_I[dram_seq_pkg::SEL_MSB:dram_seq_pkg::SEL_LSB];
    // control readback, bit 3 reserved and read as zero
    assign ctrl_view = {25'h0, s_q.special_command_sel, 1'b0, s_q.burst_size_sel,
        s_q.sdram_kind};
    // Status: suspended, not running, clock enables latched
    assign status_view = {29'h0, s_q.suspended, s_q.pstate != PS_RUN, s_q.cke_on};

    // The exit cycle counts as asleep so CKE rises in the same cycle the exit command appears
    assign sleeping = s_q.pstate == PS_SELF_REFRESH || s_q.pstate == PS_EXIT;
    // light low-power exit needs no software; suspend waits for reset
    assign wake_ok = !s_q.suspended && !lp_seen;

    always_comb begin
        s_d = s_q;
        s_d.sus_sync = {s_q.sus_sync[0], SUSPEND_REQ_I};
        s_d.lp_sync = {s_q.lp_sync[0], LOWPOWER_REQ_I};
        s_d.cmd.valid = 1'b0;
        s_d.cmd.cmd = dram_seq_pkg::CMD_NOP;
        s_d.sdram_kind = dram_seq_pkg::KIND_DDR;
        s_d.rdata = 32'h0;

        // mode field written from the control register
        if (ctrl_wr) begin
            s_d.special_command_sel = wr_sel;
            s_d.burst_size_sel = REG_WDATA_I[dram_seq_pkg::BURST_BIT];
            // first nonzero write raises clock enables
            if (wr_sel != SEL_OFF) begin
                s_d.cke_on = 1'b1;
            end
        end
        // Read data stand one cycle, zero for unmapped addresses
        if (ctrl_rd) begin
            s_d.rdata = ctrl_view;
        end else if (status_rd) begin
            s_d.rdata = status_view;
        end

        if (!burst_idle) begin
            s_d.beats_left = s_q.beats_left - BEAT_STEP;
        end

        case (s_q.pstate)
            PS_RUN: begin
                if (flush_go) begin
                    s_d.pstate = PS_FLUSH;
                end else if (cmd_ok) begin
                    s_d.cmd.valid = 1'b1;
                    s_d.cmd.addr = plain_lines;
                    s_d.cmd.beats = BEATS_NONE;
                    case (dram_seq_pkg::mode_t'(s_q.special_command_sel))
                        dram_seq_pkg::MODE_NOP: begin
                            s_d.cmd.cmd = dram_seq_pkg::CMD_NOP;
                        end
                        dram_seq_pkg::MODE_PRECHARGE: begin
                            s_d.cmd.cmd = dram_seq_pkg::CMD_PRECHARGE_ALL;
                        end
                        dram_seq_pkg::MODE_MRS: begin
                            s_d.cmd.cmd = dram_seq_pkg::CMD_MODE_SET;
                            s_d.row_col = mrs_lines;
                        end
                        dram_seq_pkg::MODE_CBR: begin
                            s_d.cmd.cmd = dram_seq_pkg::CMD_REFRESH;
                        end
                        dram_seq_pkg::MODE_NORMAL: begin
                            s_d.cmd.cmd = CPU_WRITE_I ? dram_seq_pkg::CMD_WRITE
                                : dram_seq_pkg::CMD_READ;
                            s_d.row_col = plain_lines;
                            s_d.cmd.beats = burst_beats;
                            s_d.beats_left = burst_beats;
                        end
                        // reserved codes and the post-reset code issue nothing
                        default: begin
                            s_d.cmd.valid = 1'b0;
                        end
                    endcase
                end
            end
            PS_FLUSH: begin
                // enter self-refresh once the burst drains
                // A running burst is never cut short by a power request
                if (burst_idle) begin
                    s_d.cmd.valid = 1'b1;
                    s_d.cmd.cmd = dram_seq_pkg::CMD_SR_ENTER;
                    s_d.suspended = s_q.sus_sync[1];
                    s_d.pstate = PS_SELF_REFRESH;
                end
            end
            PS_SELF_REFRESH: begin
                // hardware exit, suspend waits for reset
                if (wake_ok) begin
                    s_d.pstate = PS_EXIT;
                end
            end
            PS_EXIT: begin
                // CKE stays low in this cycle and rises with the return to run
                s_d.cmd.valid = 1'b1;
                s_d.cmd.cmd = dram_seq_pkg::CMD_SR_EXIT;
                s_d.pstate = PS_RUN;
            end
            default: s_d.pstate = PS_RUN;
        endcase
    end

    // reset clears mode, clock enables low
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_q <= '0;
            s_q.special_command_sel <= dram_seq_pkg::SEL_RESET;
            s_q.burst_size_sel <= dram_seq_pkg::BURST_RESET;
            s_q.sdram_kind <= dram_seq_pkg::KIND_DDR;
            s_q.pstate <= PS_RUN;
        end else if (CLK_EN_I) begin
            s_q <= s_d;
        end
    end

    // clock enables low until enabled and awake
    // All ranks share one source so they never disagree
    genvar g;
    generate
        for (g = 0; g < RANKS; g++) begin : g_cke
            assign CKE_O[g] = s_q.cke_on && !sleeping;
        end
    endgenerate

    // Outputs come straight from the state flops
    assign SELF_REFRESH_O = s_q.pstate == PS_SELF_REFRESH;
    assign MEM_CMD_O = s_q.cmd;
    assign DRAM_ROW_COL_LINES_O = s_q.row_col;
    assign REG_RDATA_O = s_q.rdata;
endmodule : dram_special_mode_sequencer
`default_nettype wire

// *** test/dram_seq_asserts.sv ***
// Port-level checks for the special-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_seq_asserts #(
    parameter int RANKS = 4
) (
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic CPU_REQ_I,
    input wire logic CPU_WRITE_I,
    input wire logic [31:0] CPU_ADDRESS_BITS_I,
    input wire logic CPU_READY_O,
    input wire logic SUSPEND_REQ_I,
    input wire logic LOWPOWER_REQ_I,
    input wire logic SELF_REFRESH_O,
    input wire dram_seq_pkg::mem_cmd_t MEM_CMD_O,
    input wire logic [13:0] DRAM_ROW_COL_LINES_O,
    input wire logic [RANKS-1:0] CKE_O
);
    logic [2:0] md_q;
    logic bq_q;
    wire logic wt = REG_WR_I && CLK_EN_I && REG_ADDR_I == dram_seq_pkg::ADDR_CTRL;
    wire logic tk = CPU_REQ_I && CPU_READY_O && CLK_EN_I && &CKE_O;
    // Shadow of the control fields, so checks need no view inside
    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            md_q <= 3'h0;
            bq_q <= 1'h0;
        end else if (wt) begin
            md_q <= REG_WDATA_I[6:4];
            bq_q <= REG_WDATA_I[2];
        end
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    property p_rst; $rose(RESET_N_I) |-> CKE_O == '0; endproperty
    property p_on; wt && |REG_WDATA_I[6:4] && !SELF_REFRESH_O |=> &CKE_O; endproperty
    property p_mrs; tk && md_q == 3'h3 |=> MEM_CMD_O.cmd == dram_seq_pkg::CMD_MODE_SET; endproperty
    property p_map; tk && md_q == 3'h3 |=> DRAM_ROW_COL_LINES_O ==
        {2'h0, $past(CPU_ADDRESS_BITS_I[13]), 1'h0, $past(CPU_ADDRESS_BITS_I[12:3])}; endproperty
    property p_bst; tk && md_q == 3'h7 && !CPU_WRITE_I |=> MEM_CMD_O.valid &&
        MEM_CMD_O.beats == (bq_q ? 4'h8 : 4'h4); endproperty
    property p_rd; REG_RD_I && REG_ADDR_I == dram_seq_pkg::ADDR_CTRL |=>
        {REG_RDATA_O[6:4], REG_RDATA_O[2:0]} == {md_q, bq_q, 2'h1}; endproperty
    property p_lpin; $rose(LOWPOWER_REQ_I) && &CKE_O |-> ##[2:20] SELF_REFRESH_O && CKE_O == '0;
    endproperty
    property p_lpout; $fell(LOWPOWER_REQ_I) && SELF_REFRESH_O && !SUSPEND_REQ_I |-> ##[2:8] &CKE_O;
    endproperty
    a_rst: assert property (p_rst) else $error("clock enable high after reset");
    a_on: assert property (p_on) else $error("clock enable not raised");
    a_mrs: assert property (p_mrs) else $error("mode set command missing");
    a_map: assert property (p_map) else $error("mode set address wrong");
    a_bst: assert property (p_bst) else $error("read beat count wrong");
    a_rd: assert property (p_rd) else $error("control readback wrong");
    a_lpin: assert property (p_lpin) else $error("no self-refresh entry");
    a_lpout: assert property (p_lpout) else $error("no self-refresh exit");
    c_mrs: cover property (tk && md_q == 3'h3);
    c_long: cover property (tk && md_q == 3'h7 && bq_q);
    c_sr: cover property ($rose(SELF_REFRESH_O));
endmodule : dram_seq_asserts
bind dram_special_mode_sequencer dram_seq_asserts #(.RANKS(RANKS)) u_asserts (.*);
`default_nettype wire

// *** test/sdram_module_model.sv ***
// Memory module model that keeps the mode register loaded by mode set commands
`timescale 1ns/1ps
`default_nettype none
module sdram_module_model #(
    parameter int RANKS = 4
) (
    input wire logic clk_i,
    input wire dram_seq_pkg::mem_cmd_t cmd_i,
    input wire logic [13:0] lines_i,
    input wire logic [RANKS-1:0] cke_i,
    output logic [13:0] mode_reg_o
);
    always @(posedge clk_i) begin
        if (cmd_i.valid && cmd_i.cmd == dram_seq_pkg::CMD_MODE_SET && &cke_i) begin
            mode_reg_o <= lines_i;
        end
    end
endmodule : sdram_module_model
`default_nettype wire

// *** test/dram_special_mode_sequencer_tb_top.sv ***
// Self-checking bench for the special-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module dram_special_mode_sequencer_tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, req = 0, we = 0, sus = 0, lp = 0, sr, rdy;
    logic [7:0] ra = 0;
    logic [31:0] wd = 0, ca = 0, rdata, seed = 32'h85ea, a;
    logic [13:0] rcl, mr;
    logic [3:0] cke;
    logic [2:0] ml [9] = '{1, 2, 3, 6, 4, 5, 0, 7, 7};
    dram_seq_pkg::mem_cmd_t mc;
    int n_mismatch = 0, compares = 0, i, k;
    dram_special_mode_sequencer dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1),
        .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .CPU_REQ_I(req), .CPU_WRITE_I(we), .CPU_ADDRESS_BITS_I(ca), .CPU_READY_O(rdy),
        .SUSPEND_REQ_I(sus), .LOWPOWER_REQ_I(lp), .SELF_REFRESH_O(sr), .MEM_CMD_O(mc),
        .DRAM_ROW_COL_LINES_O(rcl), .CKE_O(cke));
    sdram_module_model mem (.clk_i(clk), .cmd_i(mc), .lines_i(rcl), .cke_i(cke), .mode_reg_o(mr));
    initial forever #12.5 clk = ~clk;
    function automatic logic [3:0] exp_cmd(input logic [2:0] m, input logic w);
        case (m)
            3'h1: return {1'h1, dram_seq_pkg::CMD_NOP};
            3'h2: return {1'h1, dram_seq_pkg::CMD_PRECHARGE_ALL};
            3'h3: return {1'h1, dram_seq_pkg::CMD_MODE_SET};
            3'h6: return {1'h1, dram_seq_pkg::CMD_REFRESH};
            3'h7: return {1'h1, w ? dram_seq_pkg::CMD_WRITE : dram_seq_pkg::CMD_READ};
            default: return 4'h0;
        endcase
    endfunction : exp_cmd
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wreg(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk) {ra, wd, wr} <= {ad, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [7:0] ad, input logic [31:0] e);
        @(posedge clk) {ra, rd} <= {ad, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rreg
    task results;
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        #100000 n_mismatch++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        chk(cke, 4'h0);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rreg(dram_seq_pkg::ADDR_CTRL, 32'h1);
        rreg(8'h08, 32'h0);
        for (i = 0; i < 9; i++) begin
            a = $random(seed);
            a[5:3] = 3'h3;
            wreg(dram_seq_pkg::ADDR_CTRL, {ml[i], 1'h0, i != 8, 2'h0});
            rreg(dram_seq_pkg::ADDR_CTRL, {ml[i], 1'h0, i != 8, 2'h1});
            chk(cke, 4'hf);
            @(posedge clk) {req, we, ca} <= {1'b1, a[31], a};
            for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge clk);
            @(posedge clk) req <= 1'b0;
            #1 chk({mc.valid, mc.valid ? mc.cmd : 3'h0}, exp_cmd(ml[i], a[31]));
            if (ml[i] == 3'h7) chk(mc.beats, i != 8 ? 4'h8 : 4'h4);
        end
        chk(mr[2:0], 3'h3);
        repeat (10) @(posedge clk) lp <= 1'b1;
        for (k = 0; k < 40 && sr !== 1'b1; k++) @(posedge clk);
        #1 chk({sr, cke}, 5'h10);
        rreg(dram_seq_pkg::ADDR_STATUS, 32'h3);
        @(posedge clk) lp <= 1'b0;
        for (k = 0; k < 40 && cke !== 4'hf; k++) @(posedge clk);
        #1 chk({sr, cke}, 5'h0f);
        @(posedge clk) sus <= 1'b1;
        for (k = 0; k < 40 && sr !== 1'b1; k++) @(posedge clk);
        #1 chk({sr, cke}, 5'h10);
        rreg(dram_seq_pkg::ADDR_STATUS, 32'h7);
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk) sus <= 1'b0;
        rst_n <= 1'b1;
        @(posedge clk) #1 chk(cke, 4'h0);
        rreg(dram_seq_pkg::ADDR_CTRL, 32'h1);
        results();
    end
endmodule : dram_special_mode_sequencer_tb_top
`default_nettype wire
